// *** rtl/aed_map.vh ***
`ifndef AED_MAP_VH
`define AED_MAP_VH
// Bus master codes.
`define AED_MST_CPU 1'b0
`define AED_MST_DMA 1'b1
// Access size codes.
`define AED_SZ_BYTE 2'h0
`define AED_SZ_WORD 2'h1
`define AED_SZ_LONG 2'h2
// Default peripheral window and its 16-bit sub-area.
`define AED_PERI_BASE 32'h05FF_FE00
`define AED_PERI_LAST 32'h05FF_FFFF
`define AED_P16_BASE 32'h05FF_FE00
`define AED_P16_LAST 32'h05FF_FEFF
// Byte offset of the address error entry in the vector table.
`define AED_VEC_OFFS 32'h0000_0024
// Stack push step in bytes.
`define AED_PUSH_STEP 32'h0000_0004
`endif

// *** rtl/aed_check.v ***
`timescale 1ns/100ps
`include "aed_map.vh"
// Pure decode of one bus cycle; the caller ANDs the result with cyc_valid_i without registering it.
module aed_check #(
    parameter [31:0] PERI_BASE = `AED_PERI_BASE,
    parameter [31:0] PERI_LAST = `AED_PERI_LAST,
    parameter [31:0] P16_BASE = `AED_P16_BASE,
    parameter [31:0] P16_LAST = `AED_P16_LAST
) (
    input wire fetch_i,
    input wire [1:0] size_i,
    input wire [31:0] addr_i,
    output reg err_o
);
    wire in_peri = (addr_i >= PERI_BASE) && (addr_i <= PERI_LAST);
    wire in_p16 = (addr_i >= P16_BASE) && (addr_i <= P16_LAST);
    always @* begin
        err_o = 1'b0;
        if (fetch_i) begin
            err_o = addr_i[0] | in_peri;
        end else if (size_i == `AED_SZ_WORD) begin
            err_o = addr_i[0];
        end else if (size_i == `AED_SZ_LONG) begin
            err_o = (addr_i[1:0] != 2'b00) | (in_peri & ~in_p16);
        end
    end
endmodule

// *** rtl/aed_stack_wr.v ***
`timescale 1ns/100ps
`include "aed_map.vh"
// Computes one pushed stack slot: predecrement then write.
module aed_stack_wr (
    input wire [31:0] sp_i,
    output wire [31:0] new_sp_o
);
    assign new_sp_o = sp_i - `AED_PUSH_STEP;
endmodule

// *** rtl/aed_top.v ***
`timescale 1ns/100ps
`include "aed_map.vh"
// Notes on behaviour
// - Odd-address CPU fetch is an address error.
// - CPU fetch from peripheral region always errors; DMA fetch is decoded as a data access.
// - Even fetch outside peripherals is normal.
// - Odd word data access errors, either master.
// - Unaligned long data access errors.
// - Byte/word peripheral data accesses never region errors.
// - Long access to 16-bit peripherals accepted.
// - Long access to 8-bit peripherals errors.
// - Entry waits for bus cycle, instructions.
// - First push the status word.
// - Then push next instruction's address.
// - Read vector entry, resume there.
// - Handler jump has no delay slot.
module aed_top (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire cyc_valid_i,
    input wire cyc_master_i,
    input wire cyc_fetch_i,
    input wire [1:0] cyc_size_i,
    input wire [31:0] cyc_addr_i,
    input wire cyc_done_i,
    input wire insn_busy_i,
    input wire [31:0] status_word_i,
    input wire [31:0] program_counter_next_i,
    input wire [31:0] sp_i,
    input wire [31:0] vbr_i,
    output wire cyc_err_o,
    output reg [1:0] err_master_o,
    output wire exc_busy_o,
    output reg mem_wr_o,
    output reg mem_rd_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    output reg sp_wr_o,
    output reg [31:0] sp_o,
    output reg pc_load_o,
    output reg [31:0] pc_o,
    output wire slot_kill_o
);
    // =====================================================
    // Error detection
    // =====================================================
    wire err_now;
    aed_check u_check (
        .fetch_i(cyc_fetch_i & (cyc_master_i == `AED_MST_CPU)),
        .size_i(cyc_size_i),
        .addr_i(cyc_addr_i),
        .err_o(err_now)
    );
    assign cyc_err_o = cyc_valid_i & err_now;

    // =====================================================
    // Entry sequencer
    // =====================================================
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_WAIT = 7'h02;
    localparam [6:0] S_PSR = 7'h04;
    localparam [6:0] S_PPC = 7'h08;
    localparam [6:0] S_VEC = 7'h10;
    localparam [6:0] S_JMP = 7'h20;
    localparam [6:0] S_END = 7'h40;
    reg [6:0] st_q;
    reg [31:0] sp_q;
    reg [31:0] pc_save_q;
    reg cyc_open_q;
    wire [31:0] sp_dec;
    aed_stack_wr u_stack (
        .sp_i(sp_q),
        .new_sp_o(sp_dec)
    );
    assign exc_busy_o = (st_q != S_IDLE);
    // The slot after the handler jump is suppressed, so no delayed branch.
    assign slot_kill_o = (st_q == S_JMP);

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= S_IDLE;
            sp_q <= 32'h0000_0000;
            pc_save_q <= 32'h0000_0000;
            cyc_open_q <= 1'b0;
            err_master_o <= 2'b00;
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_addr_o <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
            sp_wr_o <= 1'b0;
            sp_o <= 32'h0000_0000;
            pc_load_o <= 1'b0;
            pc_o <= 32'h0000_0000;
        end else begin
            sp_wr_o <= 1'b0;
            pc_load_o <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (cyc_valid_i && err_now) begin
                        err_master_o <= {cyc_master_i, 1'b1};
                        cyc_open_q <= ~cyc_done_i;
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (cyc_done_i) begin
                        cyc_open_q <= 1'b0;
                    end
                    // Both the faulting cycle and current instructions must drain.
                    if ((!cyc_open_q || cyc_done_i) && !insn_busy_i) begin
                        sp_q <= sp_i;
                        pc_save_q <= program_counter_next_i;
                        mem_wr_o <= 1'b1;
                        mem_addr_o <= sp_i - `AED_PUSH_STEP;
                        mem_wdata_o <= status_word_i;
                        st_q <= S_PSR;
                    end
                end
                S_PSR: begin
                    if (mem_ack_i) begin
                        sp_q <= sp_dec;
                        mem_addr_o <= sp_dec - `AED_PUSH_STEP;
                        mem_wdata_o <= pc_save_q;
                        st_q <= S_PPC;
                    end
                end
                S_PPC: begin
                    if (mem_ack_i) begin
                        mem_wr_o <= 1'b0;
                        sp_q <= sp_dec;
                        sp_wr_o <= 1'b1;
                        sp_o <= sp_dec;
                        mem_rd_o <= 1'b1;
                        mem_addr_o <= vbr_i + `AED_VEC_OFFS;
                        st_q <= S_VEC;
                    end
                end
                S_VEC: begin
                    if (mem_ack_i) begin
                        mem_rd_o <= 1'b0;
                        pc_o <= mem_rdata_i;
                        pc_load_o <= 1'b1;
                        st_q <= S_JMP;
                    end
                end
                S_JMP: begin
                    st_q <= S_END;
                end
                S_END: begin
                    err_master_o <= 2'b00;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// *** bench/aed_chk.sv ***
`timescale 1ns/100ps
`include "aed_map.vh"
module aed_chk (
    input wire sys_clk_i, rst_n_i, cyc_valid_i, cyc_master_i, cyc_fetch_i,
    input wire [1:0] cyc_size_i,
    input wire [31:0] cyc_addr_i, status_word_i, sp_i, mem_addr_o, mem_wdata_o,
    input wire insn_busy_i, cyc_err_o, mem_wr_o, pc_load_o, slot_kill_o, mem_rd_o, sp_wr_o
);
    wire f = cyc_valid_i & ~cyc_master_i & cyc_fetch_i;
    wire d = cyc_valid_i & ~f;
    wire pe = cyc_addr_i >= `AED_PERI_BASE && cyc_addr_i <= `AED_PERI_LAST;
    wire p8 = pe && cyc_addr_i > `AED_P16_LAST;
    wire lg = d && cyc_size_i == 2'h2;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_push; mem_wr_o && mem_addr_o == sp_i - `AED_PUSH_STEP && mem_wdata_o == status_word_i; endsequence
    property p_fo; f && cyc_addr_i[0] |-> cyc_err_o; endproperty
    a_fo: assert property (p_fo) else $error("odd fetch");
    property p_fp; f && pe |-> cyc_err_o; endproperty
    a_fp: assert property (p_fp) else $error("peri fetch");
    property p_wo; d && cyc_size_i == 2'h1 && cyc_addr_i[0] |-> cyc_err_o; endproperty
    a_wo: assert property (p_wo) else $error("odd word");
    property p_lu; lg && cyc_addr_i[1:0] != 2'h0 |-> cyc_err_o; endproperty
    a_lu: assert property (p_lu) else $error("odd long");
    property p_sp; d && pe && cyc_size_i < 2'h2 && !(cyc_size_i[0] && cyc_addr_i[0]) |-> !cyc_err_o; endproperty
    a_sp: assert property (p_sp) else $error("peri small");
    property p_l16; lg && pe && !p8 && cyc_addr_i[1:0] == 2'h0 |-> !cyc_err_o; endproperty
    a_l16: assert property (p_l16) else $error("long p16");
    property p_l8; lg && p8 |-> cyc_err_o; endproperty
    a_l8: assert property (p_l8) else $error("long p8");
    property p_wt; $rose(mem_wr_o) |-> !$past(insn_busy_i) ##0 s_push; endproperty
    a_wt: assert property (p_wt) else $error("early push");
    property p_sk; pc_load_o |-> slot_kill_o; endproperty
    a_sk: assert property (p_sk) else $error("no kill");
    property p_sw; $rose(mem_rd_o) |-> sp_wr_o; endproperty
    a_sw: assert property (p_sw) else $error("no sp update");
endmodule
bind aed_top aed_chk c_u (.*);

// *** bench/aed_mem_model.sv ***
`timescale 1ns/100ps
module aed_mem_model (
    input wire clk, rst_n, wr, rd,
    input wire [31:0] addr, wdata,
    output logic ack,
    output logic [31:0] rdata
);
    int dly;
    logic n;
    logic [31:0] la [2];
    logic [31:0] ld [2];
    // Random wait states; read data is noise except in the acknowledged cycle.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 0; dly <= 1; n <= 0;
        end else if ((wr || rd) && !ack && dly == 0) begin
            ack <= 1; rdata <= ~addr; dly <= $urandom % 4;
            if (wr) begin la[n] <= addr; ld[n] <= wdata; n <= ~n; end
        end else begin
            ack <= 0; rdata <= $urandom;
            if (dly != 0) dly <= dly - 1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`include "aed_map.vh"
module tb_top;
    logic sys_clk_i = 0, rst_n_i = 0, cyc_valid_i = 0, cyc_master_i = 0, cyc_fetch_i = 0, cyc_done_i = 0;
    logic insn_busy_i = 0, mem_ack_i, cyc_err_o, exc_busy_o, mem_wr_o, mem_rd_o, sp_wr_o, pc_load_o, slot_kill_o;
    logic [1:0] cyc_size_i = 0, err_master_o;
    logic [31:0] cyc_addr_i = 0, status_word_i = 0, program_counter_next_i = 0, sp_i = 0, vbr_i = 0;
    logic [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, sp_o, pc_o;
    int fails = 0, check_count = 0, i;
    always #2.5 sys_clk_i = ~sys_clk_i;
    aed_top dut_u (.*);
    aed_mem_model m_u (.clk(sys_clk_i), .rst_n(rst_n_i), .wr(mem_wr_o), .rd(mem_rd_o), .addr(mem_addr_o),
        .wdata(mem_wdata_o), .ack(mem_ack_i), .rdata(mem_rdata_i));
    task chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin fails++; $display("[ERR] %0s exp %h got %h", n, e, s); end
    endtask
    function logic ex(input logic m, f, input logic [1:0] s, input logic [31:0] a);
        logic pe;
        pe = a >= `AED_PERI_BASE && a <= `AED_PERI_LAST;
        if (!m && f) return a[0] | pe;
        if (s == 2'h1) return a[0];
        if (s == 2'h2) return a[1:0] != 2'h0 || pe && a > `AED_P16_LAST;
        return 0;
    endfunction
    task final_report;
        $display("fails=%0d checks=%0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Decode is checked while entry is parked, so later faults must not restart it.
    task round(input logic m);
        rst_n_i <= 0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1; insn_busy_i <= 1; cyc_done_i <= 0; status_word_i <= $urandom;
        program_counter_next_i <= $urandom; sp_i <= $urandom & ~3; vbr_i <= $urandom & ~3;
        @(posedge sys_clk_i);
        cyc_valid_i <= 1; cyc_master_i <= m; cyc_fetch_i <= 0; cyc_size_i <= 1; cyc_addr_i <= 32'h0000_1001;
        for (i = 0; i < 400; i++) begin
            @(posedge sys_clk_i);
            cyc_master_i <= $urandom; cyc_fetch_i <= $urandom; cyc_size_i <= $urandom % 3; cyc_done_i <= i > 300;
            cyc_addr_i <= ($urandom % 2) ? `AED_PERI_BASE + $urandom % 512 : $urandom;
            @(negedge sys_clk_i);
            chk("err", cyc_err_o, ex(cyc_master_i, cyc_fetch_i, cyc_size_i, cyc_addr_i));
        end
        chk("mst", err_master_o, {m, 1'b1});
        chk("wr", mem_wr_o, 0);
        @(posedge sys_clk_i);
        cyc_valid_i <= 0; insn_busy_i <= 0;
        for (i = 0; i < 100 && pc_load_o !== 1; i++) @(negedge sys_clk_i);
        if (i == 100) begin fails++; final_report; end
        chk("pc", pc_o, ~(vbr_i + `AED_VEC_OFFS));
        chk("kill", slot_kill_o, 1);
        chk("sp", sp_o, sp_i - 8);
        chk("busy", exc_busy_o, 1);
        chk("a0", m_u.la[0], sp_i - 4);
        chk("d0", m_u.ld[0], status_word_i);
        chk("a1", m_u.la[1], sp_i - 8);
        chk("d1", m_u.ld[1], program_counter_next_i);
        @(negedge sys_clk_i);
        chk("kill off", slot_kill_o, 0);
        $display("round %0d end", m);
    endtask
    initial begin
        void'($urandom(76765));
        repeat (8) @(posedge sys_clk_i);
        round(0);
        round(1);
        final_report;
    end
endmodule
